// ===== tt2_pkg.sv
// constants and carrier types of the second timer/counter block
// assumes an 8-bit register port on the ref_clk domain
`default_nettype none
package tt2_pkg;
	// register addresses on the special-function bus
	localparam logic [7:0] TT2_ADDR_CTRL = 8'hC8;
	localparam logic [7:0] TT2_ADDR_MODE = 8'hC9;
	localparam logic [7:0] TT2_ADDR_CAP_LOW = 8'hCA;
	localparam logic [7:0] TT2_ADDR_CAP_HIGH = 8'hCB;
	localparam logic [7:0] TT2_ADDR_COUNT_LOW = 8'hCC;
	localparam logic [7:0] TT2_ADDR_COUNT_HIGH = 8'hCD;
	localparam logic [7:0] TT2_ADDR_INT_STATUS = 8'hCE;
	localparam logic [7:0] TT2_ADDR_INT_MASK = 8'hCF;
	// reset values
	localparam logic [7:0] TT2_CTRL_RESET = 8'h00;
	localparam logic [7:0] TT2_BYTE_RESET = 8'h00;
	localparam logic [15:0] TT2_COUNT_RESET = 16'h0000;
	localparam logic [15:0] TT2_COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] TT2_COUNT_STEP = 16'h0001;
	// field positions
	localparam int TT2_MODE_DOWN_COUNT_ENABLE_BIT = 0;
	localparam int TT2_INT_OVF_BIT = 0;
	localparam int TT2_INT_EXT_BIT = 1;
	localparam int TT2_INT_BITS = 2;
	// timing: oscillator periods per machine cycle and per state time
	localparam int TT2_OSC_PER_MC = 12;
	localparam int TT2_OSC_PER_STATE = 2;
	localparam logic [3:0] TT2_DIV_LAST = 4'(TT2_OSC_PER_MC - 1);
	localparam logic [3:0] TT2_DIV_STEP = 4'h1;
	localparam logic [3:0] TT2_DIV_ZERO = 4'h0;

	typedef struct packed {
		logic overflow_flag;
		logic external_event_flag;
		logic rx_clock_source_sel;
		logic tx_clock_source_sel;
		logic external_trigger_enable;
		logic run_control;
		logic function_select;
		logic capture_reload_select;
	} tt2_ctrl_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tt2_bus_req_t;
endpackage : tt2_pkg
`default_nettype wire

// ===== tt2_timer.sv
// second 16-bit timer/counter: control, count, capture/reload, baud ticks
// assumes a one-cycle register port on ref_clk and asynchronous pins
`default_nettype none
module tt2_timer (
	input wire logic ref_clk, // 100 MHz oscillator clock
	input wire logic arst_n, // asynchronous reset, active low
	input wire tt2_pkg::tt2_bus_req_t bus_req, // register request
	output logic [7:0] rd_data, // read data, cycle after read strobe
	input wire logic external_count_pin, // external count input
	input wire logic external_trigger_pin, // capture/reload/direction pin
	input wire logic other_timer_ovf, // overflow pulse of the other timer
	output logic rx_baud_tick, // receive clock pulse to serial port
	output logic tx_baud_tick, // transmit clock pulse to serial port
	output logic irq // timer interrupt, level
);
	import tt2_pkg::*;

	tt2_ctrl_t ctrl_r, ctrl_nxt;
	logic down_count_enable_r;
	logic [15:0] count_r, count_nxt;
	logic [15:0] cap_r, cap_nxt;
	logic [TT2_INT_BITS-1:0] status_r, status_nxt, mask_r;
	logic [3:0] div_r;
	logic st_phase_r;
	logic cnt_meta_r, cnt_sync_r, cnt_smp_r, cnt_fall_r;
	logic trg_meta_r, trg_sync_r, trg_smp_r, trg_fall_r;
	logic [7:0] rd_data_r;
	logic rx_tick_r, tx_tick_r, irq_r;

	// address decode
	wire wr_ctrl = bus_req.wr && (bus_req.addr == TT2_ADDR_CTRL);
	wire wr_mode = bus_req.wr && (bus_req.addr == TT2_ADDR_MODE);
	wire wr_cap_lo = bus_req.wr && (bus_req.addr == TT2_ADDR_CAP_LOW);
	wire wr_cap_hi = bus_req.wr && (bus_req.addr == TT2_ADDR_CAP_HIGH);
	wire wr_cnt_lo = bus_req.wr && (bus_req.addr == TT2_ADDR_COUNT_LOW);
	wire wr_cnt_hi = bus_req.wr && (bus_req.addr == TT2_ADDR_COUNT_HIGH);
	wire wr_mask = bus_req.wr && (bus_req.addr == TT2_ADDR_INT_MASK);
	wire rd_status = bus_req.rd && (bus_req.addr == TT2_ADDR_INT_STATUS);
	wire wr_count = wr_cnt_lo || wr_cnt_hi;

	// clock dividers: machine cycle and state time enables
	wire mc_tick = (div_r == TT2_DIV_LAST);
	wire st_tick = st_phase_r;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_r <= TT2_DIV_ZERO;
			st_phase_r <= 1'b0;
		end else begin
			div_r <= mc_tick ? TT2_DIV_ZERO : div_r + TT2_DIV_STEP;
			st_phase_r <= ~st_phase_r;
		end
	end

	// pin synchronisers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_meta_r <= 1'b0;
			cnt_sync_r <= 1'b0;
			trg_meta_r <= 1'b0;
			trg_sync_r <= 1'b0;
		end else begin
			cnt_meta_r <= external_count_pin;
			cnt_sync_r <= cnt_meta_r;
			trg_meta_r <= external_trigger_pin;
			trg_sync_r <= trg_meta_r;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_smp_r <= 1'b0;
			cnt_fall_r <= 1'b0;
			trg_smp_r <= 1'b0;
			trg_fall_r <= 1'b0;
		end else begin
			cnt_fall_r <= mc_tick && cnt_smp_r && !cnt_sync_r;
			trg_fall_r <= mc_tick && trg_smp_r && !trg_sync_r;
			if (mc_tick) begin
				cnt_smp_r <= cnt_sync_r;
				trg_smp_r <= trg_sync_r;
			end
		end
	end

	// mode decode
	wire baud_mode = ctrl_r.rx_clock_source_sel || ctrl_r.tx_clock_source_sel;
	wire capture_mode = ctrl_r.capture_reload_select && !baud_mode;
	wire reload_mode = !ctrl_r.capture_reload_select && !baud_mode;
	wire count_down = reload_mode && down_count_enable_r && !trg_smp_r;
	wire updown_mode = reload_mode && down_count_enable_r;

	wire int_tick = baud_mode ? st_tick : mc_tick;
	wire src_tick = ctrl_r.function_select ? cnt_fall_r : int_tick;
	wire step = ctrl_r.run_control && src_tick;

	wire ovf_up = step && !count_down && (count_r == TT2_COUNT_MAX);
	wire uflow = step && count_down && (count_r == cap_r);
	wire trig_evt = trg_fall_r && ctrl_r.external_trigger_enable;
	wire cap_evt = trig_evt && capture_mode;
	// reload on trigger edge, not in up/down mode
	wire ext_reload = trig_evt && reload_mode && !down_count_enable_r;
	wire ext_evt = cap_evt || ext_reload || (trig_evt && baud_mode);
	wire ovf_flag_set = (ovf_up || uflow) && !baud_mode;
	wire ovf_reload = ovf_up && !capture_mode;

	// count next value, software write first
	always_comb begin
		count_nxt = count_r;
		if (wr_count) begin
			if (wr_cnt_lo) begin
				count_nxt[7:0] = bus_req.wdata;
			end else begin
				count_nxt[15:8] = bus_req.wdata;
			end
		end else if (ext_reload || ovf_reload) begin
			count_nxt = cap_r;
		end else if (uflow) begin
			count_nxt = TT2_COUNT_MAX;
		end else if (step) begin
			count_nxt = count_down ? count_r - TT2_COUNT_STEP : count_r + TT2_COUNT_STEP;
		end
	end

	always_comb begin
		cap_nxt = cap_r;
		if (cap_evt) begin
			cap_nxt = count_r;
		end else if (wr_cap_lo) begin
			cap_nxt[7:0] = bus_req.wdata;
		end else if (wr_cap_hi) begin
			cap_nxt[15:8] = bus_req.wdata;
		end
	end

	// control next value; hardware set wins over software clear
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt = tt2_ctrl_t'(bus_req.wdata);
		end
		ctrl_nxt.overflow_flag = ctrl_nxt.overflow_flag || ovf_flag_set;
		ctrl_nxt.external_event_flag = ctrl_nxt.external_event_flag || ext_evt;
	end

	// external event interrupt blocked in up/down mode
	wire [TT2_INT_BITS-1:0] int_set = {ext_evt && !updown_mode, ovf_flag_set};
	assign status_nxt = (rd_status ? {TT2_INT_BITS{1'b0}} : status_r) | int_set;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= tt2_ctrl_t'(TT2_CTRL_RESET);
			down_count_enable_r <= 1'b0;
			count_r <= TT2_COUNT_RESET;
			cap_r <= TT2_COUNT_RESET;
			status_r <= '0;
			mask_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			count_r <= count_nxt;
			cap_r <= cap_nxt;
			status_r <= status_nxt;
			if (wr_mode) begin
				down_count_enable_r <= bus_req.wdata[TT2_MODE_DOWN_COUNT_ENABLE_BIT];
			end
			if (wr_mask) begin
				mask_r <= bus_req.wdata[TT2_INT_BITS-1:0];
			end
		end
	end

	// read selection, unmapped addresses read zero
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = TT2_BYTE_RESET;
		unique case (bus_req.addr)
			TT2_ADDR_CTRL: rd_mux = ctrl_r;
			TT2_ADDR_MODE: rd_mux = {7'h00, down_count_enable_r};
			TT2_ADDR_CAP_LOW: rd_mux = cap_r[7:0];
			TT2_ADDR_CAP_HIGH: rd_mux = cap_r[15:8];
			TT2_ADDR_COUNT_LOW: rd_mux = count_r[7:0];
			TT2_ADDR_COUNT_HIGH: rd_mux = count_r[15:8];
			TT2_ADDR_INT_STATUS: rd_mux = {6'h00, status_r};
			TT2_ADDR_INT_MASK: rd_mux = {6'h00, mask_r};
			default: rd_mux = TT2_BYTE_RESET;
		endcase
	end

	wire rx_src = ctrl_r.rx_clock_source_sel ? ovf_up : other_timer_ovf;
	wire tx_src = ctrl_r.tx_clock_source_sel ? ovf_up : other_timer_ovf;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_r <= TT2_BYTE_RESET;
			rx_tick_r <= 1'b0;
			tx_tick_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			rd_data_r <= bus_req.rd ? rd_mux : TT2_BYTE_RESET;
			rx_tick_r <= rx_src;
			tx_tick_r <= tx_src;
			irq_r <= |(status_nxt & mask_r);
		end
	end

	assign rd_data = rd_data_r;
	assign rx_baud_tick = rx_tick_r;
	assign tx_baud_tick = tx_tick_r;
	assign irq = irq_r;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	a_tf_baud_block: assert property (
		$rose(ctrl_r.overflow_flag) |-> !$past(baud_mode) || $past(wr_ctrl))
		else $error("overflow flag set in baud mode");
	a_tf_on_overflow: assert property (
		(ovf_up && !baud_mode) |=> ctrl_r.overflow_flag && status_r[TT2_INT_OVF_BIT])
		else $error("overflow did not set the flag");
	a_exf_on_capture: assert property (
		cap_evt |=> ctrl_r.external_event_flag)
		else $error("capture did not set external flag");
	a_ext_irq_updown: assert property (
		$rose(status_r[TT2_INT_EXT_BIT]) |-> !$past(updown_mode))
		else $error("external event interrupt in up/down mode");
	a_rx_source: assert property (
		1'b1 |=> rx_baud_tick == $past(ctrl_r.rx_clock_source_sel ? ovf_up : other_timer_ovf))
		else $error("receive tick from wrong source");
	a_tx_source: assert property (
		1'b1 |=> tx_baud_tick == $past(ctrl_r.tx_clock_source_sel ? ovf_up : other_timer_ovf))
		else $error("transmit tick from wrong source");
	a_trig_ignored: assert property (
		(trg_fall_r && !ctrl_r.external_trigger_enable && !bus_req.wr)
		|=> !$rose(ctrl_r.external_event_flag))
		else $error("disabled trigger edge acted");
	a_stopped_hold: assert property (
		(!ctrl_r.run_control && !bus_req.wr && !trg_fall_r) |=> $stable(count_r))
		else $error("count moved while stopped");
	a_timer_rate: assert property (
		(ctrl_r.run_control && !ctrl_r.function_select && !baud_mode && !mc_tick
		&& !bus_req.wr && !trg_fall_r) |=> $stable(count_r))
		else $error("timer advanced off machine cycle");
	a_capture_copy: assert property (
		cap_evt |=> cap_r == $past(count_r))
		else $error("capture bytes do not match count");
	a_reload_overflow: assert property (
		(ovf_up && !capture_mode && !wr_count) |=> count_r == $past(cap_r))
		else $error("overflow did not reload");

	c_capture: cover property (cap_evt);
	c_baud_overflow: cover property (ovf_up && baud_mode);
	c_down_underflow: cover property (uflow);
	c_irq_raised: cover property ($rose(irq));
endmodule : tt2_timer
`default_nettype wire

// ===== tt2_pins_model.sv
// far-side model: count pin, trigger pin and the other timer's overflow pulse
// assumes the block's ref_clk; both pins idle high as with port pull-ups
`default_nettype none
module tt2_pins_model (
	input wire logic ref_clk, // block clock
	output logic count_pin, // external count input
	output logic trig_pin, // external trigger input
	output logic other_ovf // other timer overflow pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		count_pin = 1'b1;
		trig_pin = 1'b1;
		other_ovf = 1'b0;
	end
	task automatic fall(input bit trig);
		repeat (30) @(posedge ref_clk);
		if (trig) begin
			trig_pin <= 1'b0;
		end else begin
			count_pin <= 1'b0;
		end
		repeat (30) @(posedge ref_clk);
		trig_pin <= 1'b1;
		count_pin <= 1'b1;
	endtask : fall
	task automatic ovf_pulse;
		@(posedge ref_clk);
		other_ovf <= 1'b1;
		@(posedge ref_clk);
		other_ovf <= 1'b0;
	endtask : ovf_pulse
	// direction level on the trigger pin
	task automatic hold_trig(input bit lvl);
		@(posedge ref_clk);
		trig_pin <= lvl;
	endtask : hold_trig
endmodule : tt2_pins_model
`default_nettype wire

// ===== tb_timer_two_control.sv
// self-checking bench of the second timer/counter
// assumes tt2_pkg and tt2_timer compiled first, pins from tt2_pins_model
`default_nettype none
module tb_timer_two_control;
	import tt2_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	tt2_bus_req_t req = '0;
	logic [7:0] rd_data, d;
	logic cnt_pin, trig_pin, other_ovf, rx_t, tx_t, irq;
	int err_total = 0;
	int n_tests = 0;
	int rx_n = 0;
	int tx_n = 0;
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		rx_n <= rx_n + int'(rx_t);
		tx_n <= tx_n + int'(tx_t);
	end
	tt2_timer i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .bus_req(req), .rd_data(rd_data),
		.external_count_pin(cnt_pin), .external_trigger_pin(trig_pin),
		.other_timer_ovf(other_ovf), .rx_baud_tick(rx_t), .tx_baud_tick(tx_t), .irq(irq));
	tt2_pins_model i_pins (.ref_clk(ref_clk), .count_pin(cnt_pin), .trig_pin(trig_pin),
		.other_ovf(other_ovf));
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		req.addr <= a;
		req.wdata <= v;
		req.wr <= 1'b1;
		@(posedge ref_clk);
		req.wr <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge ref_clk);
		req.rd <= 1'b0;
		#1 d = rd_data;
		chk(name, d, exp);
	endtask : rdchk
	task automatic t_reset;
		rdchk("ctrl", TT2_ADDR_CTRL, TT2_CTRL_RESET);
		rdchk("unmapped", 8'hC0, 8'h00);
		$display("test reset done");
	endtask : t_reset
	task automatic t_overflow;
		wr(TT2_ADDR_CAP_LOW, 8'hF0);
		wr(TT2_ADDR_CAP_HIGH, 8'hFF);
		wr(TT2_ADDR_COUNT_LOW, 8'hFF);
		wr(TT2_ADDR_COUNT_HIGH, 8'hFF);
		wr(TT2_ADDR_INT_MASK, 8'h01);
		wr(TT2_ADDR_CTRL, 8'h04);
		repeat (20) @(posedge ref_clk);
		wr(TT2_ADDR_CTRL, 8'h80);
		rdchk("reload high", TT2_ADDR_COUNT_HIGH, 8'hFF);
		rdchk("ovf flag", TT2_ADDR_CTRL, 8'h80);
		chk("irq on", {7'h0, irq}, 8'h01);
		rdchk("status", TT2_ADDR_INT_STATUS, 8'h01);
		@(posedge ref_clk);
		#1 chk("irq off", {7'h0, irq}, 8'h00);
		wr(TT2_ADDR_CTRL, 8'h00);
		rdchk("flag clear", TT2_ADDR_CTRL, 8'h00);
		wr(TT2_ADDR_COUNT_LOW, 8'hFF);
		wr(TT2_ADDR_CTRL, 8'h05);
		repeat (20) @(posedge ref_clk);
		wr(TT2_ADDR_CTRL, 8'h01);
		rdchk("wrap high", TT2_ADDR_COUNT_HIGH, 8'h00);
		rdchk("wrap status", TT2_ADDR_INT_STATUS, 8'h01);
		wr(TT2_ADDR_COUNT_LOW, 8'h5A);
		rdchk("stopped", TT2_ADDR_COUNT_LOW, 8'h5A);
		repeat (30) @(posedge ref_clk);
		rdchk("still", TT2_ADDR_COUNT_LOW, 8'h5A);
		$display("test overflow done");
	endtask : t_overflow
	task automatic t_baud;
		wr(TT2_ADDR_CTRL, 8'h00);
		wr(TT2_ADDR_CAP_LOW, 8'hFE);
		wr(TT2_ADDR_COUNT_LOW, 8'hFF);
		wr(TT2_ADDR_COUNT_HIGH, 8'hFF);
		rx_n = 0;
		tx_n = 0;
		wr(TT2_ADDR_CTRL, 8'h24);
		repeat (40) @(posedge ref_clk);
		rdchk("no flag", TT2_ADDR_CTRL, 8'h24);
		chk("rx ticks", {7'h0, rx_n > 0}, 8'h01);
		chk("tx quiet", 8'(tx_n), 8'h00);
		i_pins.ovf_pulse();
		repeat (3) @(posedge ref_clk);
		chk("tx other", 8'(tx_n), 8'h01);
		wr(TT2_ADDR_CTRL, 8'h00);
		$display("test baud done");
	endtask : t_baud
	task automatic t_capture;
		wr(TT2_ADDR_COUNT_LOW, 8'hCD);
		wr(TT2_ADDR_COUNT_HIGH, 8'hAB);
		wr(TT2_ADDR_CTRL, 8'h09);
		i_pins.fall(1'b1);
		rdchk("cap low", TT2_ADDR_CAP_LOW, 8'hCD);
		rdchk("cap high", TT2_ADDR_CAP_HIGH, 8'hAB);
		rdchk("ext flag", TT2_ADDR_CTRL, 8'h49);
		chk("irq masked", {7'h0, irq}, 8'h00);
		rdchk("ext status", TT2_ADDR_INT_STATUS, 8'h02);
		wr(TT2_ADDR_CTRL, 8'h01);
		i_pins.fall(1'b1);
		rdchk("ignored", TT2_ADDR_CTRL, 8'h01);
		$display("test capture done");
	endtask : t_capture
	task automatic t_counter;
		wr(TT2_ADDR_COUNT_LOW, 8'h00);
		wr(TT2_ADDR_COUNT_HIGH, 8'h00);
		wr(TT2_ADDR_CTRL, 8'h06);
		repeat (3) i_pins.fall(1'b0);
		wr(TT2_ADDR_CTRL, 8'h00);
		rdchk("edges", TT2_ADDR_COUNT_LOW, 8'h03);
		$display("test counter done");
	endtask : t_counter
	// count down with the trigger pin held low until the capture value is met
	task automatic t_updown;
		wr(TT2_ADDR_CAP_LOW, 8'h10);
		wr(TT2_ADDR_CAP_HIGH, 8'h00);
		wr(TT2_ADDR_COUNT_LOW, 8'h11);
		wr(TT2_ADDR_COUNT_HIGH, 8'h00);
		wr(TT2_ADDR_MODE, 8'h01);
		i_pins.hold_trig(1'b0);
		repeat (30) @(posedge ref_clk);
		wr(TT2_ADDR_CTRL, 8'h04);
		repeat (40) @(posedge ref_clk);
		wr(TT2_ADDR_CTRL, 8'h80);
		rdchk("down flag", TT2_ADDR_CTRL, 8'h80);
		rdchk("down high", TT2_ADDR_COUNT_HIGH, 8'hFF);
		rdchk("down status", TT2_ADDR_INT_STATUS, 8'h01);
		i_pins.hold_trig(1'b1);
		wr(TT2_ADDR_MODE, 8'h00);
		wr(TT2_ADDR_CTRL, 8'h00);
		$display("test updown done");
	endtask : t_updown
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_reset();
		t_overflow();
		t_baud();
		t_capture();
		t_counter();
		t_updown();
		print_verdict();
	end
	// the tests need about 600 cycles; this limit is over sixteen times that
	initial begin
		#100000;
		err_total++;
		print_verdict();
	end
endmodule : tb_timer_two_control
`default_nettype wire
